//--- include/dio_pkg.sv
/*
 Constants for the drive input function and relay select block: register offsets,
 function codes, relay select codes and reset values.
 Assumes a 32-bit APB register bus with byte addresses in the low eight bits.
*/
package dio_pkg;
    localparam int          CODE_W      = 5;
    localparam int          ADDR_W      = 8;
    localparam int          RETRY_W     = 8;

    // Discrete input function codes
    localparam logic [4:0]  FN_NONE     = 5'h00;
    localparam logic [4:0]  FN_ACC2     = 5'h01;
    localparam logic [4:0]  FN_JOG      = 5'h02;
    localparam logic [4:0]  FN_AUXF     = 5'h03;
    localparam logic [4:0]  FN_PRESET   = 5'h04;
    localparam logic [4:0]  FN_LOCAL    = 5'h05;
    localparam logic [4:0]  FN_COMM     = 5'h06;
    localparam logic [4:0]  FN_CLRF     = 5'h07;
    localparam logic [4:0]  FN_RSTOP    = 5'h08;
    localparam logic [4:0]  FN_CSTOP    = 5'h09;
    localparam logic [4:0]  FN_DSTOP    = 5'h0a;
    localparam logic [4:0]  FN_JOGF     = 5'h0b;
    localparam logic [4:0]  FN_JOGR     = 5'h0c;
    localparam logic [4:0]  FN_ANV      = 5'h0d;
    localparam logic [4:0]  FN_ANI      = 5'h0e;
    localparam logic [4:0]  FN_INV      = 5'h1a;

    // Relay select codes
    localparam logic [4:0]  RS_READY    = 5'h00;
    localparam logic [4:0]  RS_ATFREQ   = 5'h01;
    localparam logic [4:0]  RS_RUN      = 5'h02;
    localparam logic [4:0]  RS_REV      = 5'h03;
    localparam logic [4:0]  RS_OVLD     = 5'h04;
    localparam logic [4:0]  RS_RAMP     = 5'h05;
    localparam logic [4:0]  RS_FREQ     = 5'h06;
    localparam logic [4:0]  RS_CUR      = 5'h07;
    localparam logic [4:0]  RS_BUS      = 5'h08;
    localparam logic [4:0]  RS_RETRY    = 5'h09;
    localparam logic [4:0]  RS_ANLG     = 5'h0a;
    localparam logic [4:0]  RS_NET      = 5'h14;
    localparam logic [4:0]  RS_NONREC   = 5'h15;

    // Register byte offsets
    localparam logic [7:0]  ADDR_IN1    = 8'h00;
    localparam logic [7:0]  ADDR_IN2    = 8'h04;
    localparam logic [7:0]  ADDR_RSEL   = 8'h08;
    localparam logic [7:0]  ADDR_RLVL   = 8'h0c;
    localparam logic [7:0]  ADDR_RETRY  = 8'h10;
    localparam logic [7:0]  ADDR_LEVELS = 8'h14;
    localparam logic [7:0]  ADDR_ACTIVE = 8'h18;
    localparam logic [7:0]  ADDR_FAULT  = 8'h1c;

    // Reset values, network-on relay level and aux fault clear bit
    localparam logic [4:0]  IN_FN_RST   = FN_PRESET;
    localparam logic [4:0]  RSEL_RST    = RS_READY;
    localparam logic [31:0] RLVL_RST    = 32'h0000_0000;
    localparam logic [7:0]  RETRY_RST   = 8'h00;
    localparam logic [31:0] NET_ON      = 32'h0000_0001;
    localparam int          AUX_CLR_BIT = 0;
endpackage

//--- include/dio_if.sv
/*
 Carrier between the register top and the relay condition selector.
 Assumes both ends share pclk; the selector is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface dio_if #(parameter int MEAS_W = 16);
    logic [4:0]        sel;
    logic [31:0]       level;
    logic [MEAS_W-1:0] out_freq;
    logic [MEAS_W-1:0] out_cur;
    logic [MEAS_W-1:0] bus_v;
    logic [MEAS_W-1:0] anlg_v;
    logic              at_freq;
    logic              running;
    logic              rev_cmd;
    logic              overload;
    logic              ramp_reg;
    logic              ready;
    logic              fault;
    logic [7:0]        retries;
    logic [7:0]        retry_limit;
    logic              cond;

    modport cfg (output sel, level, out_freq, out_cur, bus_v, anlg_v, at_freq, running, rev_cmd,
                 overload, ramp_reg, ready, fault, retries, retry_limit, input cond);
    modport rly (input sel, level, out_freq, out_cur, bus_v, anlg_v, at_freq, running, rev_cmd,
                 overload, ramp_reg, ready, fault, retries, retry_limit, output cond);
endinterface
`default_nettype wire

//--- src/dio_relay.sv
/*
 Relay condition selector: picks the drive condition that the relay follows.
 Assumes the top registers the result before it reaches the relay pin.
*/
`timescale 1ns/1ps
`default_nettype none
module dio_relay #(
    parameter int MEAS_W = 16
) (
    dio_if.rly bus
);
    if (MEAS_W < 8 || MEAS_W > 32) begin
        $error("dio_relay: MEAS_W out of range");
    end

    function automatic logic above(input logic [MEAS_W-1:0] v, input logic [31:0] lvl);
        above = ({{(32-MEAS_W){1'b0}}, v} > lvl);
    endfunction

    wire logic f_above  = above(bus.out_freq, bus.level);
    wire logic c_above  = above(bus.out_cur, bus.level);
    wire logic v_above  = above(bus.bus_v, bus.level);
    wire logic a_above  = above(bus.anlg_v, bus.level);
    wire logic retry_ex = (bus.retries > bus.retry_limit);

    wire logic [11:0] cv = {(bus.level == dio_pkg::NET_ON), a_above, retry_ex, v_above, c_above, f_above,
                            bus.ramp_reg, bus.overload, bus.rev_cmd, bus.running, bus.at_freq,
                            bus.ready && !bus.fault};

    // Conditions come in as an argument so the assignment follows every change of them
    function automatic logic pick(input logic [4:0] s, input logic [11:0] c);
        unique case (s)
            dio_pkg::RS_READY:  pick = c[0];
            dio_pkg::RS_ATFREQ: pick = c[1];
            dio_pkg::RS_RUN:    pick = c[2];
            dio_pkg::RS_REV:    pick = c[3];
            dio_pkg::RS_OVLD:   pick = c[4];
            dio_pkg::RS_RAMP:   pick = c[5];
            dio_pkg::RS_FREQ:   pick = c[6];
            dio_pkg::RS_CUR:    pick = c[7];
            dio_pkg::RS_BUS:    pick = c[8];
            dio_pkg::RS_RETRY:  pick = c[9];
            dio_pkg::RS_NONREC: pick = c[9];
            dio_pkg::RS_ANLG:   pick = c[10];
            dio_pkg::RS_NET:    pick = c[11];
            default:            pick = 1'b0;
        endcase
    endfunction

    assign bus.cond = pick(bus.sel, cv);
endmodule
`default_nettype wire

//--- src/dio_top.sv
/*
 Discrete input function mapper and relay select for a motor drive, with APB registers.
 Assumes the two input pins are asynchronous, drive state inputs share pclk, and the
 motor-control core acts on the command outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module dio_top #(
    parameter int MEAS_W = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [1:0]        din_pin,
    input  wire logic              start_valid,
    input  wire logic              drive_ready,
    input  wire logic              fault_active,
    input  wire logic              at_freq,
    input  wire logic              motor_running,
    input  wire logic              reverse_cmd,
    input  wire logic              motor_overload,
    input  wire logic              ramp_reg_active,
    input  wire logic [MEAS_W-1:0] out_freq,
    input  wire logic [MEAS_W-1:0] out_current_pct,
    input  wire logic [MEAS_W-1:0] bus_voltage,
    input  wire logic [MEAS_W-1:0] analog_voltage,
    input  wire logic [7:0]        restart_count,
    output logic                   accel2_sel,
    output logic                   jog_run,
    output logic                   jog_reverse,
    output logic      [1:0]        preset_bits,
    output logic                   preset_active,
    output logic                   keypad_source,
    output logic                   comm_source,
    output logic                   fault_clear,
    output logic                   forced_ramp_stop,
    output logic                   forced_coast_stop,
    output logic                   forced_injection_stop,
    output logic                   analog_v_ref,
    output logic                   analog_i_ref,
    output logic                   analog_invert,
    output logic                   auxiliary_input_fault,
    output logic                   relay_out
);
    if (MEAS_W < 8 || MEAS_W > 32) begin
        $error("dio_top: MEAS_W out of range");
    end

    logic [4:0]  in_fn_q [2];
    logic [4:0]  relay_sel_q;
    logic [31:0] relay_lvl_q;
    logic [7:0]  retry_lim_q;
    logic [1:0]  pin_meta_q;
    logic [1:0]  lvl_q;
    logic [1:0]  lvl_rb_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [15:0] cmd_q;
    logic [15:0] cmd_d;
    logic        aux_q;
    logic        relay_q;

    // Any input programmed to f and active
    function automatic logic fn_hit(input logic [4:0] c0, input logic l0,
                                    input logic [4:0] c1, input logic l1, input logic [4:0] f);
        fn_hit = (c0 == f && l0) || (c1 == f && l1);
    endfunction

    // Single-input code: input 1 owns it when both are programmed alike
    function automatic logic fn_one(input logic [4:0] c0, input logic l0,
                                    input logic [4:0] c1, input logic l1, input logic [4:0] f);
        fn_one = (c0 == f) ? l0 : (c1 == f && l1);
    endfunction

    // Pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= 2'h0;
            lvl_q      <= 2'h0;
        end else begin
            pin_meta_q <= din_pin;
            lvl_q      <= pin_meta_q;
        end
    end

    wire logic [4:0] c0 = in_fn_q[0];
    wire logic [4:0] c1 = in_fn_q[1];
    wire logic       l0 = lvl_q[0];
    wire logic       l1 = lvl_q[1];

    // Command decode; codes 0 and reserved codes match nothing
    wire logic jog_any  = fn_hit(c0, l0, c1, l1, dio_pkg::FN_JOG)
                        || fn_hit(c0, l0, c1, l1, dio_pkg::FN_JOGF)
                        || fn_hit(c0, l0, c1, l1, dio_pkg::FN_JOGR);
    wire logic jog_rev  = fn_hit(c0, l0, c1, l1, dio_pkg::FN_JOGR);
    wire logic aux_set  = (c0 == dio_pkg::FN_AUXF && !l0) || (c1 == dio_pkg::FN_AUXF && !l1);
    wire logic clr_pin  = fn_hit(c0, l0, c1, l1, dio_pkg::FN_CLRF);
    wire logic [1:0] ps = {c1 == dio_pkg::FN_PRESET && l1, c0 == dio_pkg::FN_PRESET && l0};

    always_comb begin
        cmd_d     = 16'h0000;
        cmd_d[0]  = fn_one(c0, l0, c1, l1, dio_pkg::FN_ACC2);
        cmd_d[1]  = jog_any && !start_valid;
        cmd_d[2]  = jog_rev && !start_valid;
        cmd_d[4:3] = ps;
        cmd_d[5]  = |ps;
        cmd_d[6]  = fn_hit(c0, l0, c1, l1, dio_pkg::FN_LOCAL);
        cmd_d[7]  = fn_one(c0, l0, c1, l1, dio_pkg::FN_COMM);
        cmd_d[8]  = clr_pin;
        cmd_d[9]  = fn_hit(c0, l0, c1, l1, dio_pkg::FN_RSTOP);
        cmd_d[10] = fn_hit(c0, l0, c1, l1, dio_pkg::FN_CSTOP);
        cmd_d[11] = fn_hit(c0, l0, c1, l1, dio_pkg::FN_DSTOP);
        cmd_d[12] = fn_hit(c0, l0, c1, l1, dio_pkg::FN_ANV);
        cmd_d[13] = fn_hit(c0, l0, c1, l1, dio_pkg::FN_ANI);
        cmd_d[14] = fn_hit(c0, l0, c1, l1, dio_pkg::FN_INV);
    end

    // APB decode
    wire logic setup    = psel && !penable;
    wire logic acc_done = psel && penable && pready_q;
    wire logic wr_en    = acc_done && pwrite;
    wire logic hit_in1  = (paddr == dio_pkg::ADDR_IN1);
    wire logic hit_in2  = (paddr == dio_pkg::ADDR_IN2);
    wire logic hit_rsel = (paddr == dio_pkg::ADDR_RSEL);
    wire logic hit_rlvl = (paddr == dio_pkg::ADDR_RLVL);
    wire logic hit_rtry = (paddr == dio_pkg::ADDR_RETRY);
    wire logic hit_lvls = (paddr == dio_pkg::ADDR_LEVELS);
    wire logic hit_actv = (paddr == dio_pkg::ADDR_ACTIVE);
    wire logic hit_flt  = (paddr == dio_pkg::ADDR_FAULT);
    wire logic addr_ok  = hit_in1 || hit_in2 || hit_rsel || hit_rlvl || hit_rtry
                        || hit_lvls || hit_actv || hit_flt;
    wire logic aux_wclr = wr_en && hit_flt && pwdata[dio_pkg::AUX_CLR_BIT];
    wire logic aux_d    = aux_set || (aux_q && !(clr_pin || aux_wclr));

    wire logic [31:0] rd_data =
          hit_in1  ? {27'h0, in_fn_q[0]}
        : hit_in2  ? {27'h0, in_fn_q[1]}
        : hit_rsel ? {27'h0, relay_sel_q}
        : hit_rlvl ? relay_lvl_q
        : hit_rtry ? {24'h0, retry_lim_q}
        : hit_lvls ? {30'h0, lvl_rb_q}
        : hit_actv ? {15'h0, relay_q, cmd_q}
        : hit_flt  ? {31'h0, aux_q}
        : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !addr_ok;
            prdata_q  <= setup ? rd_data : prdata_q;
        end
    end

    // Configuration registers; the host stops the drive before changing codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_fn_q[0]  <= dio_pkg::IN_FN_RST;
            in_fn_q[1]  <= dio_pkg::IN_FN_RST;
            relay_sel_q <= dio_pkg::RSEL_RST;
            relay_lvl_q <= dio_pkg::RLVL_RST;
            retry_lim_q <= dio_pkg::RETRY_RST;
        end else if (wr_en) begin
            if (hit_in1) begin
                in_fn_q[0] <= pwdata[4:0];
            end
            if (hit_in2) begin
                in_fn_q[1] <= pwdata[4:0];
            end
            if (hit_rsel) begin
                relay_sel_q <= pwdata[4:0];
            end
            if (hit_rlvl) begin
                relay_lvl_q <= pwdata;
            end
            if (hit_rtry) begin
                retry_lim_q <= pwdata[7:0];
            end
        end
    end

    dio_if #(.MEAS_W(MEAS_W)) rif ();

    assign rif.sel         = relay_sel_q;
    assign rif.level       = relay_lvl_q;
    assign rif.out_freq    = out_freq;
    assign rif.out_cur     = out_current_pct;
    assign rif.bus_v       = bus_voltage;
    assign rif.anlg_v      = analog_voltage;
    assign rif.at_freq     = at_freq;
    assign rif.running     = motor_running;
    assign rif.rev_cmd     = reverse_cmd;
    assign rif.overload    = motor_overload;
    assign rif.ramp_reg    = ramp_reg_active;
    assign rif.ready       = drive_ready;
    assign rif.fault       = fault_active;
    assign rif.retries     = restart_count;
    assign rif.retry_limit = retry_lim_q;

    dio_relay #(.MEAS_W(MEAS_W)) u_relay (
        .bus (rif.rly)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q    <= 16'h0000;
            aux_q    <= 1'b0;
            relay_q  <= 1'b0;
            lvl_rb_q <= 2'h0;
        end else begin
            cmd_q    <= cmd_d;
            aux_q    <= aux_d;
            relay_q  <= rif.cond;
            lvl_rb_q <= lvl_q;
        end
    end

    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign accel2_sel            = cmd_q[0];
    assign jog_run               = cmd_q[1];
    assign jog_reverse           = cmd_q[2];
    assign preset_bits           = cmd_q[4:3];
    assign preset_active         = cmd_q[5];
    assign keypad_source         = cmd_q[6];
    assign comm_source           = cmd_q[7];
    assign fault_clear           = cmd_q[8];
    assign forced_ramp_stop      = cmd_q[9];
    assign forced_coast_stop     = cmd_q[10];
    assign forced_injection_stop = cmd_q[11];
    assign analog_v_ref          = cmd_q[12];
    assign analog_i_ref          = cmd_q[13];
    assign analog_invert         = cmd_q[14];
    assign auxiliary_input_fault = aux_q;
    assign relay_out             = relay_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable && pready_q;
    endsequence

    a_apb_answer: assert property (s_setup |=> pready_q && (pslverr_q == !$past(addr_ok)))
        else $error("apb answer missing");
    a_apb_single: assert property (s_access |=> !pready_q)
        else $error("pready held too long");
    a_none_quiet: assert property (c0 == dio_pkg::FN_NONE && c1 == dio_pkg::FN_NONE
        && !start_valid |=> cmd_q == 16'h0000 && lvl_rb_q == $past(lvl_q))
        else $error("unused inputs acted");
    a_acc2_owner: assert property (c0 == dio_pkg::FN_ACC2 && c1 == dio_pkg::FN_ACC2
        && !l0 && l1 |=> !accel2_sel)
        else $error("second ramp taken from input two");
    a_jog_start: assert property (jog_any |=> jog_run == !$past(start_valid))
        else $error("jog precedence wrong");
    a_aux_fault: assert property (aux_set |=> auxiliary_input_fault [*2])
        else $error("aux fault not held");
    a_preset_bits: assert property (1'b1 |=> preset_bits == $past(ps)
        && preset_active == |$past(ps))
        else $error("preset bits wrong");
    a_comm_owner: assert property (c0 == dio_pkg::FN_COMM && c1 == dio_pkg::FN_COMM
        && !l0 && l1 |=> !comm_source)
        else $error("comm source taken from input two");
    a_coast_stop: assert property (fn_hit(c0, l0, c1, l1, dio_pkg::FN_CSTOP)
        |=> forced_coast_stop && !forced_ramp_stop == !$past(fn_hit(c0, l0, c1, l1, dio_pkg::FN_RSTOP)))
        else $error("coast stop missed");
    a_relay_ready: assert property (relay_sel_q == dio_pkg::RS_READY
        |=> relay_out == $past(drive_ready && !fault_active))
        else $error("ready relay wrong");
    a_relay_net: assert property (relay_sel_q == dio_pkg::RS_NET
        |=> relay_out == ($past(relay_lvl_q) == dio_pkg::NET_ON))
        else $error("network relay wrong");
    a_relay_rsvd: assert property (relay_sel_q > dio_pkg::RS_ANLG && relay_sel_q < dio_pkg::RS_NET
        |=> !relay_out)
        else $error("reserved relay code drove relay");
endmodule
`default_nettype wire

//--- test/dio_core_model.sv
/*
 Stand-in for the drive core: a ready flag some cycles after reset and a latched fault.
 Assumes the block's aux fault and fault clear outputs share pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dio_core_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic aux_fault,
    input  wire logic clear,
    output logic      ready,
    output logic      fault
);
    logic [2:0] cnt_q;

    // Clear wins so a held clear input keeps the core healthy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 3'h0;
            ready <= 1'b0;
            fault <= 1'b0;
        end else begin
            if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
            ready <= (cnt_q == 3'h7);
            if (clear) fault <= 1'b0;
            else if (aux_fault) fault <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- test/testbench.sv
/*
 Self-checking bench for dio_top: APB master, drive state stimulus, core model.
 Assumes a 100 ns pclk and registered block outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sv = 1'b0;
    logic [7:0]  paddr = '0, rc = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic        pready, pslverr, e, rdy, flt, aux, relay_out;
    logic [1:0]  din = '0;
    logic [4:0]  cnd = '0;
    logic [15:0] ms [4] = '{default: '0};
    logic [14:0] cmd;
    int          err_total = 0, checks = 0;

    always #50 pclk = ~pclk;

    dio_core_model u_core (.pclk, .presetn, .aux_fault(aux), .clear(cmd[8]), .ready(rdy), .fault(flt));
    dio_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .din_pin(din), .start_valid(sv), .drive_ready(rdy), .fault_active(flt),
        .at_freq(cnd[0]), .motor_running(cnd[1]), .reverse_cmd(cnd[2]), .motor_overload(cnd[3]),
        .ramp_reg_active(cnd[4]), .out_freq(ms[0]), .out_current_pct(ms[1]), .bus_voltage(ms[2]),
        .analog_voltage(ms[3]), .restart_count(rc), .accel2_sel(cmd[0]), .jog_run(cmd[1]),
        .jog_reverse(cmd[2]), .preset_bits(cmd[4:3]), .preset_active(cmd[5]), .keypad_source(cmd[6]),
        .comm_source(cmd[7]), .fault_clear(cmd[8]), .forced_ramp_stop(cmd[9]),
        .forced_coast_stop(cmd[10]), .forced_injection_stop(cmd[11]), .analog_v_ref(cmd[12]),
        .analog_i_ref(cmd[13]), .analog_invert(cmd[14]), .auxiliary_input_fault(aux), .relay_out);

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; waits for pready, then takes data at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input string n, input logic x);
        wt(3);
        chk(n, {31'h0, relay_out}, {31'h0, x});
    endtask

    task automatic t_reset;
        apb(1'b0, dio_pkg::ADDR_IN1, '0);
        chk("in1 code", q, 32'h4);
        apb(1'b0, dio_pkg::ADDR_IN2, '0);
        chk("in2 code", q, 32'h4);
        apb(1'b0, dio_pkg::ADDR_RSEL, '0);
        chk("relay sel", q, '0);
        apb(1'b0, 8'h20, '0);
        chk("unmapped", {q[30:0], e}, 32'h1);
        rchk("ready relay", 1'b1);
    endtask

    task automatic t_codes;
        logic [4:0]  cl [17] = '{5'h0, 5'h1, 5'h2, 5'h3, 5'h4, 5'h5, 5'h6, 5'h7, 5'h8, 5'h9,
                                 5'ha, 5'hb, 5'hc, 5'hd, 5'he, 5'hf, 5'h1a};
        logic [14:0] fxt [15] = '{15'h0, 15'h1, 15'h2, 15'h0, 15'h28, 15'h40, 15'h80, 15'h100,
                                  15'h200, 15'h400, 15'h800, 15'h2, 15'h6, 15'h1000, 15'h2000};
        logic [14:0] x;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, k ? dio_pkg::ADDR_IN1 : dio_pkg::ADDR_IN2, '0);
            foreach (cl[i]) begin
                apb(1'b1, k ? dio_pkg::ADDR_IN2 : dio_pkg::ADDR_IN1, {27'h0, cl[i]});
                x = cl[i] == 5'h1a ? 15'h4000 : cl[i] > 5'he ? 15'h0 : (cl[i] == 5'h4 && k == 1) ? 15'h30 : fxt[cl[i]];
                din <= 2'(1 << k);
                wt(4);
                chk("cmd active", 32'(cmd), 32'(x));
                if (cl[i] == 5'h0) begin
                    apb(1'b0, dio_pkg::ADDR_LEVELS, '0);
                    chk("levels", q, {30'h0, din});
                end
                din <= '0;
                wt(4);
                chk("cmd idle", 32'(cmd), '0);
            end
        end
    endtask

    task automatic t_aux;
        din <= 2'b01;
        wt(4);
        apb(1'b1, dio_pkg::ADDR_IN1, 32'h3);
        apb(1'b1, dio_pkg::ADDR_FAULT, 32'h1);
        apb(1'b0, dio_pkg::ADDR_FAULT, '0);
        chk("aux held", q, '0);
        din <= '0;
        wt(4);
        apb(1'b0, dio_pkg::ADDR_FAULT, '0);
        chk("aux set", q, 32'h1);
        rchk("fault relay", 1'b0);
        apb(1'b1, dio_pkg::ADDR_IN1, 32'h7);
        din <= 2'b01;
        wt(4);
        apb(1'b0, dio_pkg::ADDR_FAULT, '0);
        chk("aux cleared", q, '0);
        rchk("relay back", 1'b1);
    endtask

    task automatic t_jog;
        apb(1'b1, dio_pkg::ADDR_IN1, 32'hb);
        sv <= 1'b1;
        wt(4);
        chk("jog overridden", {31'h0, cmd[1]}, '0);
        sv <= 1'b0;
        wt(3);
        chk("jog", {31'h0, cmd[1]}, 32'h1);
        din <= '0;
        apb(1'b1, dio_pkg::ADDR_IN1, '0);
    endtask

    // Both inputs share a single-owner code; only input 1 may act on it
    task automatic t_owner;
        for (int f = 1; f < 7; f += 5) begin
            apb(1'b1, dio_pkg::ADDR_IN1, 32'(f));
            apb(1'b1, dio_pkg::ADDR_IN2, 32'(f));
            din <= 2'b10;
            wt(4);
            chk("owner in2", 32'(cmd), '0);
            din <= 2'b01;
            wt(4);
            chk("owner in1", 32'(cmd), f == 1 ? 32'h1 : 32'h80);
            din <= '0;
        end
        apb(1'b1, dio_pkg::ADDR_IN1, '0);
        apb(1'b1, dio_pkg::ADDR_IN2, '0);
    endtask

    task automatic t_relay;
        apb(1'b1, dio_pkg::ADDR_RLVL, 32'h64);
        apb(1'b1, dio_pkg::ADDR_RETRY, 32'h3);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, dio_pkg::ADDR_RSEL, 32'(i + 1));
            cnd <= 5'(1 << i);
            rchk("cond on", 1'b1);
            cnd <= ~5'(1 << i);
            rchk("cond off", 1'b0);
        end
        cnd <= '0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, dio_pkg::ADDR_RSEL, i == 3 ? 32'ha : 32'(i + 6));
            ms[i] <= 16'h65;
            rchk("above", 1'b1);
            ms[i] <= 16'h64;
            rchk("at level", 1'b0);
        end
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, dio_pkg::ADDR_RSEL, i ? 32'h15 : 32'h9);
            rc <= 8'h4;
            rchk("retries", 1'b1);
            rc <= 8'h3;
            rchk("retries ok", 1'b0);
        end
        apb(1'b1, dio_pkg::ADDR_RSEL, 32'h14);
        apb(1'b1, dio_pkg::ADDR_RLVL, 32'h1);
        rchk("net on", 1'b1);
        apb(1'b1, dio_pkg::ADDR_RLVL, '0);
        rchk("net off", 1'b0);
        apb(1'b1, dio_pkg::ADDR_RSEL, 32'hb);
        cnd <= '1;
        rc <= 8'hff;
        rchk("reserved", 1'b0);
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        wt(12);
        presetn <= 1'b1;
        wt(1);
        t_reset;
        t_codes;
        t_aux;
        t_jog;
        t_owner;
        t_relay;
        end_sim;
    end

    initial begin
        #1_000_000;
        err_total++;
        end_sim;
    end
endmodule
`default_nettype wire
